// ### dv/rbpf_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module rbpf_monitor #(
   parameter int NUM_BUF = 8
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic               hready,
   input  wire logic               hreadyout,
   input  wire logic               hresp,
   input  wire logic [31:0]        hrdata,
   input  wire logic               pkt_valid,
   input  wire logic               pkt_ready,
   input  wire logic               accept_valid,
   input  wire logic [NUM_BUF-1:0] accept_mask
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_take;
      pkt_valid && pkt_ready;
   endsequence
   sequence s_gap_read;
      hsel && hready && htrans[1] && !hwrite && haddr < 32'h0000_0354;
   endsequence

   bus_no_wait_a: assert property (hreadyout)
      else $error("hreadyout low");
   bus_resp_okay_a: assert property (!hresp)
      else $error("hresp not okay");
   gap_read_zero_a: assert property (s_gap_read |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   scan_busy_a: assert property (s_take |=> !pkt_ready [*8])
      else $error("ready during scan");
   no_early_result_a: assert property (s_take |=> !accept_valid [*8])
      else $error("result too early");
   result_due_a: assert property (s_take |-> ##[34:70] accept_valid)
      else $error("result missing");
   result_pulse_a: assert property (accept_valid |=> !accept_valid)
      else $error("result pulse too long");
   ready_on_result_a: assert property (accept_valid |-> pkt_ready)
      else $error("not ready at result");
   mask_hold_a: assert property ($changed(accept_mask) |-> accept_valid)
      else $error("mask changed without result");
endmodule

bind rbpf_top rbpf_monitor #(.NUM_BUF(NUM_BUF)) i_rbpf_monitor (
   .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
   .accept_valid(accept_valid), .accept_mask(accept_mask));

`default_nettype wire

// ### dv/rbpf_pkt_src.sv
`timescale 1ns/100ps
`default_nettype none

module rbpf_pkt_src (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        req,
   input  wire logic        r_async,
   input  wire logic [47:0] r_dest,
   input  wire logic [15:0] r_sid,
   input  wire logic [31:0] r_hdr,
   input  wire logic [15:0] r_len,
   input  wire logic        pkt_ready,
   output logic             pkt_valid,
   output logic             pkt_async,
   output logic [47:0]      pkt_dest_offset,
   output logic [15:0]      pkt_source_id,
   output logic [31:0]      pkt_header0,
   output logic [15:0]      pkt_data_length
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pkt_valid <= 1'h0;
         pkt_async <= 1'h0;
         pkt_dest_offset <= 48'h0;
         pkt_source_id <= 16'h0;
         pkt_header0 <= 32'h0;
         pkt_data_length <= 16'h0;
      end else if (pkt_valid && pkt_ready) begin
         // Released fields scramble so stale data is never reused
         pkt_valid <= 1'h0;
         pkt_async <= ~pkt_async;
         pkt_dest_offset <= ~pkt_dest_offset;
         pkt_source_id <= ~pkt_source_id;
         pkt_header0 <= ~pkt_header0;
         pkt_data_length <= ~pkt_data_length;
      end else if (req && !pkt_valid) begin
         pkt_valid <= 1'h1;
         pkt_async <= r_async;
         pkt_dest_offset <= r_dest;
         pkt_source_id <= r_sid;
         pkt_header0 <= r_hdr;
         pkt_data_length <= r_len;
      end
   end
endmodule

`default_nettype wire

// ### dv/tb_rbpf_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_rbpf_top;
   localparam logic [31:0] BASE = rbpf_pkg::ADDR_SPACE_SELECT_OFS;
   logic        clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic        req = 1'h0, r_async = 1'h0, hreadyout, hresp, pkt_ready;
   logic        pkt_valid, pkt_async, accept_valid;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, r_hdr = 32'h0;
   logic [31:0] hrdata, hrd_q, rd, pkt_header0;
   logic [47:0] r_dest = 48'h0, pkt_dest_offset;
   logic [15:0] r_sid = 16'h0, r_len = 16'h0, pkt_source_id, pkt_data_length;
   logic [7:0]  iso = 8'h0, accept_mask, got;
   int          failures = 0;
   int          checks_done = 0;

   rbpf_top i_rbpf_top (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_async(pkt_async),
      .pkt_dest_offset(pkt_dest_offset), .pkt_source_id(pkt_source_id),
      .pkt_header0(pkt_header0), .pkt_data_length(pkt_data_length),
      .iso_buffer_mask(iso), .accept_valid(accept_valid), .accept_mask(accept_mask));
   rbpf_pkt_src i_rbpf_pkt_src (.clk(clk), .reset_n(reset_n), .req(req),
      .r_async(r_async), .r_dest(r_dest), .r_sid(r_sid), .r_hdr(r_hdr), .r_len(r_len),
      .pkt_ready(pkt_ready), .pkt_valid(pkt_valid), .pkt_async(pkt_async),
      .pkt_dest_offset(pkt_dest_offset), .pkt_source_id(pkt_source_id),
      .pkt_header0(pkt_header0), .pkt_data_length(pkt_data_length));

   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) hrd_q <= hrdata;

   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= rbpf_pkg::HTRANS_NONSEQ;
      hsize <= rbpf_pkg::HSIZE_WORD;
      do @(posedge clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      #1 rd = hrd_q;
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      ahb(1'h0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   task automatic pkt(input logic a, input logic [7:0] is, input logic [47:0] d,
                      input logic [15:0] s,
                      input logic [15:0] h, input logic [15:0] l);
      @(posedge clk);
      req <= 1'h1;
      r_async <= a;
      iso <= is;
      r_dest <= d;
      r_sid <= s;
      r_hdr <= {16'hABCD, h};
      r_len <= l;
      @(posedge clk);
      req <= 1'h0;
      for (int i = 0; i < 80 && accept_valid !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("result pulse", 32'h1, {31'h0, accept_valid});
      got = accept_mask;
   endtask
   task automatic sp(input logic [7:0] c, input logic [7:0] is, input logic [47:0] d,
                     input logic e);
      ahb(1'h1, BASE, {24'h0, c});
      pkt(1'h1, is, d, 16'h2, 16'h0, 16'h0);
      chk("space mask", {24'h0, 7'h7F, e}, {24'h0, got});
   endtask
   task automatic mt(input logic [15:0] s, input logic [15:0] h, input logic [15:0] l,
                     input logic [7:0] e);
      pkt(1'h1, 8'h0, 48'h0, s, h, l);
      chk("match mask", {24'h0, e}, {24'h0, got});
   endtask

   ////////////////////////////////////////
   task automatic t_reset;
      for (int n = 0; n < 8; n++) begin
         rdc(BASE + 32'(n) * 32'h14, 32'h0000_0080);
         for (int w = 1; w < 4; w++) rdc(BASE + 32'(n) * 32'h14 + 32'(w) * 4, 32'h0);
      end
      rdc(32'h0000_0350, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_access;
      ahb(1'h1, BASE, 32'hFFFF_FFFF);
      rdc(BASE, 32'h0000_0083);
      ahb(1'h1, 32'h0000_0350, 32'hFFFF_FFFF);
      rdc(32'h0000_0350, 32'h0);
      for (int n = 0; n < 8; n++) ahb(1'h1, BASE + 4 + 32'(n) * 32'h14, 32'(n + 1) * 32'h1111_1111);
      for (int n = 0; n < 8; n++) rdc(BASE + 4 + 32'(n) * 32'h14, 32'(n + 1) * 32'h1111_1111);
      for (int n = 0; n < 8; n++) ahb(1'h1, BASE + 4 + 32'(n) * 32'h14, 32'h0);
      $display("test access done");
   endtask
   task automatic t_space;
      sp(8'h02, 8'h0, rbpf_pkg::CONFIG_ROM_LAST, 1'h1);
      sp(8'h02, 8'h0, rbpf_pkg::INIT_UNITS_FIRST, 1'h0);
      sp(8'h01, 8'h0, rbpf_pkg::INIT_UNITS_FIRST, 1'h1);
      sp(8'h01, 8'h0, rbpf_pkg::CONFIG_ROM_FIRST, 1'h0);
      sp(8'h00, 8'h1, 48'h0000_0000_1000, 1'h1);
      sp(8'h00, 8'h0, 48'h0000_0000_1000, 1'h0);
      pkt(1'h0, 8'h0, 48'h0000_0000_1000, 16'h2, 16'h0, 16'h0);
      chk("space mask", 32'hFF, {24'h0, got});
      sp(8'h80, 8'h0, 48'h0000_0000_1000, 1'h1);
      sp(8'h82, 8'h0, 48'h0000_0000_1000, 1'h1);
      $display("test space done");
   endtask
   task automatic t_match;
      ahb(1'h1, BASE + 32'h18, 32'h0001_0000);
      ahb(1'h1, BASE + 32'h30, 32'hFFFF_1234);
      ahb(1'h1, BASE + 32'h48, 32'h00F0_0050);
      ahb(1'h1, BASE + 32'h54, 32'h0001_0000);
      ahb(1'h1, BASE + 32'h5C, 32'h00F0_0050);
      ahb(1'h1, BASE + 32'h68, 32'hFFFF_0004);
      mt(16'h4, 16'h1234, 16'h57, 8'hFF);
      mt(16'h5, 16'h1234, 16'h57, 8'hCD);
      mt(16'h6, 16'h1234, 16'h57, 8'hDF);
      mt(16'h4, 16'h1235, 16'h57, 8'hFB);
      mt(16'h4, 16'h1234, 16'h60, 8'hE7);
      pkt(1'h0, 8'h0, 48'h0, 16'h5, 16'h1234, 16'h57);
      chk("match mask", 32'hFF, {24'h0, got});
      $display("test match done");
   endtask
   task automatic t_mixed;
      // Bus read lands mid-scan; the scan slips but must stay correct
      fork
         mt(16'h4, 16'h1234, 16'h57, 8'hFF);
         begin
            repeat (4) @(posedge clk);
            rdc(BASE + 32'h68, 32'hFFFF_0004);
         end
      join
      $display("test mixed done");
   endtask

   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #1000000;
      failures++;
      end_sim;
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'h1;
      t_reset;
      t_access;
      t_space;
      t_match;
      t_mixed;
      end_sim;
   end
endmodule

`default_nettype wire

// ### pkg/rbpf_mem_if.sv
`timescale 1ns/100ps
`default_nettype none

interface rbpf_mem_if #(
   parameter int IW = 5,
   parameter int DW = 32
);
   logic          wr_en;
   logic [IW-1:0] wr_idx;
   logic [DW-1:0] wr_data;
   logic          rd_en;
   logic [IW-1:0] rd_idx;
   logic [DW-1:0] rd_data;

   modport ctrl  (output wr_en, output wr_idx, output wr_data,
                  output rd_en, output rd_idx, input rd_data);
   modport store (input wr_en, input wr_idx, input wr_data,
                  input rd_en, input rd_idx, output rd_data);
endinterface

`default_nettype wire

// ### pkg/rbpf_pkg.sv
package rbpf_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Buffer and register layout
   localparam int          NUM_BUFFERS            = 8;
   localparam int          WORDS_PER_BUF          = 4;
   localparam int          WORD_BYTES             = 4;
   localparam logic [31:0] ADDR_SPACE_SELECT_OFS  = 32'h0000_0354;
   localparam logic [31:0] SOURCE_ID_MATCH_OFS    = 32'h0000_0358;
   localparam logic [31:0] HEADER_LOW_MATCH_OFS   = 32'h0000_035C;
   localparam logic [31:0] LENGTH_MATCH_OFS       = 32'h0000_0360;
   localparam logic [31:0] BUF_STRIDE             = 32'h0000_0014;

   // Word lanes inside one buffer's group
   localparam int          LANE_ADDR_SPACE        = 0;
   localparam int          LANE_SOURCE_ID         = 1;
   localparam int          LANE_HEADER_LOW        = 2;
   localparam int          LANE_LENGTH            = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int          INIT_UNITS_BIT         = 0;
   localparam int          CONFIG_ROM_BIT         = 1;
   localparam int          ACCEPT_ALL_BIT         = 7;
   localparam int          MASK_LSB               = 16;
   localparam int          EXPECTED_LSB           = 0;
   localparam int          FIELD_W                = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and writable bits
   localparam logic [31:0] ADDR_SPACE_SELECT_RST  = 32'h0000_0080;
   localparam logic [31:0] MATCH_RST              = 32'h0000_0000;
   localparam logic [31:0] ADDR_SPACE_SELECT_WMSK = 32'h0000_0083;
   localparam logic [31:0] MATCH_WMSK             = 32'hFFFF_FFFF;

   ////////////////////////////////////////////////////////////////////////////////
   // Destination address spaces (48-bit offset)
   localparam logic [47:0] CONFIG_ROM_FIRST       = 48'hFFFF_F000_0400;
   localparam logic [47:0] CONFIG_ROM_LAST        = 48'hFFFF_F000_07FF;
   localparam logic [47:0] INIT_UNITS_FIRST       = 48'hFFFF_F000_0800;
   localparam logic [47:0] INIT_UNITS_LAST        = 48'hFFFF_FFFF_FFFF;

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite encodings
   localparam logic [1:0]  HTRANS_NONSEQ          = 2'h2;
   localparam logic [2:0]  HSIZE_WORD             = 3'h2;
   localparam logic        HRESP_OKAY             = 1'h0;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_SCAN
   } rbpf_state_t;

endpackage

// ### verilog/rbpf_cfg_mem.sv
`timescale 1ns/100ps
`default_nettype none

module rbpf_cfg_mem #(
   parameter int          DEPTH     = 32,
   parameter int          DW        = 32,
   parameter int          LANES     = 4,
   parameter logic [31:0] LANE0_RST = 32'h0000_0000,
   parameter logic [31:0] OTHER_RST = 32'h0000_0000
) (
   input  wire logic  clk,
   input  wire logic  reset_n,
   rbpf_mem_if.store  port
);

   localparam int IW = $clog2(DEPTH);

   if (DEPTH < 2 || LANES < 1 || DW != 32) begin : g_check
      $error("rbpf_cfg_mem: unsupported geometry");
   end

   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] word;
      logic [DW-1:0]            rd;
   } rbpf_mem_state_t;

   function automatic rbpf_mem_state_t init_state();
      rbpf_mem_state_t v;
      v = '0;
      for (int i = 0; i < DEPTH; i++) begin
         v.word[i] = ((i % LANES) == 0) ? LANE0_RST : OTHER_RST;
      end
      return v;
   endfunction

   localparam rbpf_mem_state_t MEM_RST = init_state();

   rbpf_mem_state_t s_r;
   rbpf_mem_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data registered; a write to the word being read is forwarded
   always_comb begin
      s_nxt = s_r;
      if (port.wr_en) begin
         s_nxt.word[port.wr_idx] = port.wr_data;
      end
      if (port.rd_en) begin
         if (port.wr_en && port.wr_idx == port.rd_idx) begin
            s_nxt.rd = port.wr_data;
         end else begin
            s_nxt.rd = s_r.word[port.rd_idx];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= MEM_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign port.rd_data = s_r.rd;

endmodule

`default_nettype wire

// ### verilog/rbpf_top.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module rbpf_top #(
   parameter int NUM_BUF = rbpf_pkg::NUM_BUFFERS
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   input  wire logic               pkt_valid,
   output logic                    pkt_ready,
   input  wire logic               pkt_async,
   input  wire logic [47:0]        pkt_dest_offset,
   input  wire logic [15:0]        pkt_source_id,
   input  wire logic [31:0]        pkt_header0,
   input  wire logic [15:0]        pkt_data_length,
   input  wire logic [NUM_BUF-1:0] iso_buffer_mask,
   output logic                    accept_valid,
   output logic [NUM_BUF-1:0]      accept_mask
);

   localparam int            LANES    = rbpf_pkg::WORDS_PER_BUF;
   localparam int            DEPTH    = NUM_BUF * LANES;
   localparam int            IW       = $clog2(DEPTH);
   localparam int            FW       = rbpf_pkg::FIELD_W;
   localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

   if (NUM_BUF < 2 || NUM_BUF > rbpf_pkg::NUM_BUFFERS) begin : g_check
      $error("rbpf_top: NUM_BUF must lie between 2 and 8");
   end

   // Lane and buffer decode split the index at its two low bits
   if (LANES != 4) begin : g_lane_check
      $error("rbpf_top: four words per buffer are required");
   end

   typedef struct packed {
      rbpf_pkg::rbpf_state_t st;
      logic                  pkt_async;
      logic [47:0]           dest;
      logic [FW-1:0]         sid;
      logic [FW-1:0]         hdr_low;
      logic [FW-1:0]         len;
      logic [NUM_BUF-1:0]    iso;
      logic [IW-1:0]         idx;
      logic                  issued_all;
      logic                  pend;
      logic [IW-1:0]         pend_idx;
      logic [2:0][31:0]      slot;
      logic [NUM_BUF-1:0]    mask;
      logic                  acc_valid;
      logic [NUM_BUF-1:0]    acc_mask;
      logic                  wr_pend;
      logic [IW-1:0]         wr_idx;
      logic                  rd_map;
   } rbpf_top_state_t;

   rbpf_top_state_t s_r;
   rbpf_top_state_t s_nxt;

   rbpf_mem_if #(.IW(IW), .DW(32)) mem_bus ();

   rbpf_cfg_mem #(
      .DEPTH     (DEPTH),
      .DW        (32),
      .LANES     (LANES),
      .LANE0_RST (rbpf_pkg::ADDR_SPACE_SELECT_RST),
      .OTHER_RST (rbpf_pkg::MATCH_RST)
   ) u_mem (
      .clk     (clk),
      .reset_n (reset_n),
      .port    (mem_bus.store)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Byte address to word index; top bit flags a hit
   function automatic logic [IW:0] decode(input logic [31:0] a);
      logic [IW:0] r;
      logic [31:0] base;
      r = '0;
      for (int b = 0; b < NUM_BUF; b++) begin
         for (int w = 0; w < LANES; w++) begin
            base = rbpf_pkg::ADDR_SPACE_SELECT_OFS + rbpf_pkg::BUF_STRIDE * 32'(b)
                   + 32'(rbpf_pkg::WORD_BYTES * w);
            if (a == base) begin
               r = {1'b1, IW'(b * LANES + w)};
            end
         end
      end
      return r;
   endfunction

   // Word lane and buffer number of a flat word index
   function automatic logic [1:0] lane_of(input logic [IW-1:0] idx);
      return idx[1:0];
   endfunction

   function automatic logic [IW-3:0] buf_of(input logic [IW-1:0] idx);
      return idx[IW-1:2];
   endfunction

   function automatic logic [31:0] wr_mask(input logic [IW-1:0] idx);
      if (lane_of(idx) == 2'(rbpf_pkg::LANE_ADDR_SPACE)) begin
         return rbpf_pkg::ADDR_SPACE_SELECT_WMSK;
      end else begin
         return rbpf_pkg::MATCH_WMSK;
      end
   endfunction

   // Masked compare of one 16-bit field against a mask/expected word
   function automatic logic field_match(input logic [31:0] cfg, input logic [FW-1:0] val);
      logic [FW-1:0] msk;
      logic [FW-1:0] exp;
      msk = cfg[rbpf_pkg::MASK_LSB +: FW];
      exp = cfg[rbpf_pkg::EXPECTED_LSB +: FW];
      return ((val ^ exp) & msk) == '0;
   endfunction

   function automatic logic in_range(input logic [47:0] a, input logic [47:0] lo,
                                     input logic [47:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic buf_accept(input logic [31:0]   sel,
                                       input logic [31:0]   sid_cfg,
                                       input logic [31:0]   hdr_cfg,
                                       input logic [31:0]   len_cfg,
                                       input logic          async_pkt,
                                       input logic [47:0]   dest,
                                       input logic [FW-1:0] sid,
                                       input logic [FW-1:0] hdr_low,
                                       input logic [FW-1:0] len,
                                       input logic          iso_buf);
      logic rom_hit;
      logic iu_hit;
      logic addr_ok;
      logic sid_ok;
      logic hdr_ok;
      logic len_ok;
      rom_hit = sel[rbpf_pkg::CONFIG_ROM_BIT]
                && in_range(dest, rbpf_pkg::CONFIG_ROM_FIRST, rbpf_pkg::CONFIG_ROM_LAST);
      iu_hit  = sel[rbpf_pkg::INIT_UNITS_BIT]
                && in_range(dest, rbpf_pkg::INIT_UNITS_FIRST, rbpf_pkg::INIT_UNITS_LAST);
      if (!async_pkt || iso_buf || sel[rbpf_pkg::ACCEPT_ALL_BIT]) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = rom_hit || iu_hit;
      end
      sid_ok = !async_pkt || field_match(sid_cfg, sid);
      hdr_ok = field_match(hdr_cfg, hdr_low);
      len_ok = field_match(len_cfg, len);
      return addr_ok && sid_ok && hdr_ok && len_ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave and filter scan

   logic [IW:0]   dec;
   logic          addr_ph;
   logic          bus_rd;
   logic          filter_rd;
   logic [IW-1:0] buf_word;

   always_comb begin
      s_nxt            = s_r;
      dec              = decode(haddr);
      addr_ph          = hsel && hready && htrans[1];
      bus_rd           = addr_ph && !hwrite && dec[IW];
      filter_rd        = 1'b0;
      buf_word         = s_r.pend_idx;
      s_nxt.acc_valid  = 1'b0;

      // Write lands in its data phase; reads take the port in the address phase
      s_nxt.rd_map  = bus_rd;
      s_nxt.wr_pend = addr_ph && hwrite && dec[IW] && hsize == rbpf_pkg::HSIZE_WORD;
      s_nxt.wr_idx  = dec[IW-1:0];

      case (s_r.st)
         rbpf_pkg::ST_IDLE: begin
            if (pkt_valid) begin
               s_nxt.st         = rbpf_pkg::ST_SCAN;
               s_nxt.pkt_async  = pkt_async;
               s_nxt.dest       = pkt_dest_offset;
               s_nxt.sid        = pkt_source_id;
               s_nxt.hdr_low    = pkt_header0[FW-1:0];
               s_nxt.len        = pkt_data_length;
               s_nxt.iso        = iso_buffer_mask;
               s_nxt.idx        = '0;
               s_nxt.issued_all = 1'b0;
               s_nxt.pend       = 1'b0;
               s_nxt.mask       = '0;
            end
         end
         rbpf_pkg::ST_SCAN: begin
            // Bus reads win the port; the scan simply slips a cycle
            filter_rd  = !bus_rd && !s_r.issued_all;
            s_nxt.pend = filter_rd;
            if (filter_rd) begin
               s_nxt.pend_idx = s_r.idx;
               if (s_r.idx == LAST_IDX) begin
                  s_nxt.issued_all = 1'b1;
               end else begin
                  s_nxt.idx = s_r.idx + IW'(1);
               end
            end
            if (s_r.pend) begin
               if (lane_of(buf_word) != 2'(rbpf_pkg::LANE_LENGTH)) begin
                  s_nxt.slot[lane_of(buf_word)] = mem_bus.rd_data;
               end else begin
                  s_nxt.mask[buf_of(buf_word)] = buf_accept(
                     s_r.slot[rbpf_pkg::LANE_ADDR_SPACE],
                     s_r.slot[rbpf_pkg::LANE_SOURCE_ID],
                     s_r.slot[rbpf_pkg::LANE_HEADER_LOW],
                     mem_bus.rd_data,
                     s_r.pkt_async, s_r.dest, s_r.sid, s_r.hdr_low, s_r.len,
                     s_r.iso[buf_of(buf_word)]);
                  if (buf_word == LAST_IDX) begin
                     s_nxt.st        = rbpf_pkg::ST_IDLE;
                     s_nxt.acc_valid = 1'b1;
                     s_nxt.acc_mask  = s_nxt.mask;
                  end
               end
            end
         end
         default: begin
            s_nxt.st = rbpf_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory port and outputs

   assign mem_bus.wr_en   = s_r.wr_pend;
   assign mem_bus.wr_idx  = s_r.wr_idx;
   assign mem_bus.wr_data = hwdata & wr_mask(s_r.wr_idx);
   assign mem_bus.rd_en   = bus_rd || filter_rd;
   assign mem_bus.rd_idx  = bus_rd ? dec[IW-1:0] : s_r.idx;

   assign hreadyout    = 1'b1;
   assign hresp        = rbpf_pkg::HRESP_OKAY;
   assign hrdata       = s_r.rd_map ? mem_bus.rd_data : 32'h0000_0000;
   assign pkt_ready    = (s_r.st == rbpf_pkg::ST_IDLE);
   assign accept_valid = s_r.acc_valid;
   assign accept_mask  = s_r.acc_mask;

endmodule

`default_nettype wire
